//--- rtl/seg_event_pkg.sv
package seg_event_pkg;
   // Register bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SEG_N  = 4;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_EVSEL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h10;

   // Event select field layout.
   localparam int EVSEL_CODE_LSB = 0;
   localparam int EVSEL_MASK_LSB = 8;
   localparam int EVSEL_EN_BIT   = 22;

   // Status, enable and clear bit positions.
   localparam int ST_WRAP_BIT  = 0;
   localparam int ST_STALL_BIT = 1;
   localparam int ST_FULL_BIT  = 2;
   localparam int ST_W         = 3;

   // Reset values.
   localparam logic [7:0]      RST_CODE   = 8'h00;
   localparam logic [7:0]      RST_MASK   = 8'h00;
   localparam logic [ST_W-1:0] RST_STATUS = 3'h0;
   localparam logic [ST_W-1:0] RST_IRQ_EN = 3'h0;

   // Event codes.
   localparam logic [7:0] EV_SEG_STALL  = 8'hd4;
   localparam logic [7:0] EV_SEG_RENAME = 8'hd5;
   localparam logic [7:0] EV_RES_STALL  = 8'hdc;

   // Unit masks; bit n of a segment mask selects ES, DS, FS, GS in turn.
   localparam logic [7:0] UM_ES       = 8'h01;
   localparam logic [7:0] UM_DS       = 8'h02;
   localparam logic [7:0] UM_FS       = 8'h04;
   localparam logic [7:0] UM_GS       = 8'h08;
   localparam logic [7:0] UM_SEG_ANY  = 8'h0f;
   localparam logic [7:0] UM_RETIRE_F = 8'h01;
   localparam logic [7:0] UM_SCHED_F  = 8'h02;
endpackage

//--- rtl/seg_rename_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module seg_rename_tracker
   import seg_event_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic [SEG_N-1:0] segUpdate,
   input  wire logic [SEG_N-1:0] segRetire,
   output logic      [SEG_N-1:0] stallHit,
   output logic      [SEG_N-1:0] renameHit,
   output logic      [SEG_N-1:0] pendingQ
);
   logic [SEG_N-1:0] pendingD;

   // One rename slot per segment; a retire in the same cycle frees the slot.
   genvar s;
   for (s = 0; s < SEG_N; s++) begin : g_seg
      assign stallHit[s]  = segUpdate[s] & pendingQ[s] & ~segRetire[s]; // [R1]
      assign renameHit[s] = segUpdate[s] & ~stallHit[s];
      assign pendingD[s]  = (pendingQ[s] & ~segRetire[s]) | renameHit[s];
   end

   // Pending bits, one per data segment register.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pendingQ <= '0;
      end else begin
         pendingQ <= pendingD;
      end
   end

   default clocking cbT @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   pend_clear_a: assert property ( // [R1]
      (|(pendingQ & segRetire & ~segUpdate))
      |=> !(|($past(pendingQ) & $past(segRetire) & ~$past(segUpdate) & pendingQ)))
      else $error("retired segment still pending");
endmodule // seg_rename_tracker
`default_nettype wire

//--- rtl/event_counter.sv
`timescale 1ns/1ps
`default_nettype none
module event_counter #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             inc,
   input  wire logic             ldEn,
   input  wire logic [WIDTH-1:0] ldVal,
   output logic      [WIDTH-1:0] countQ,
   output logic                  wrapPulse
);
   if (WIDTH < 1 || WIDTH > 32) begin : g_chk
      $error("event_counter WIDTH must be 1 to 32");
   end

   // A wrap is flagged when an increment passes the all-ones value.
   assign wrapPulse = inc & ~ldEn & (&countQ);

   // Software load wins over a same-cycle increment, so a preset is exact.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         countQ <= '0;
      end else if (ldEn) begin
         countQ <= ldVal;
      end else if (inc) begin
         countQ <= countQ + WIDTH'(1);
      end
   end
endmodule // event_counter
`default_nettype wire

//--- rtl/seg_stall_event_unit.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) A second update to an unretired renamed segment stalls the front end.
// (R2) Code D4 with mask 01 counts ES rename-resource stalls.
// (R3) Code D4 with mask 02 counts DS rename-resource stalls.
// (R4) Code D4 with mask 04 counts FS rename-resource stalls.
// (R5) Code D4 with mask 08 counts GS rename-resource stalls.
// (R6) Code D4 with mask 0F counts stalls on any of the four segments.
// (R7) Code D5 with mask 01 counts each ES rename.
// (R8) Code D5 with mask 02 counts each DS rename.
// (R9) Code D5 with mask 04 counts each FS rename.
// (R10) Code D5 with mask 08 counts each GS rename.
// (R11) Code D5 with mask 0F counts renames of any segment.
// (R12) Code DC with mask 01 counts cycles the retire buffer is full.
// (R13) Code DC with mask 02 counts cycles the scheduler is full.
// (R14) While either is full, new instructions are held off.
// (R15) Only listed code and mask pairs count; others leave the count alone.
// (R16) Segment mask bits 0..3 pick ES, DS, FS, GS; all ones picks all.
module seg_stall_event_unit
   import seg_event_pkg::*;
#(
   parameter int COUNT_W = 32
) (
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWrData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [DATA_W-1:0] regRdData_q,
   input  wire logic [SEG_N-1:0]  segUpdate,
   input  wire logic [SEG_N-1:0]  segRetire,
   input  wire logic              retireBufFull,
   input  wire logic              schedFull,
   output logic                   frontStall_q,
   output logic                   admitHold_q,
   output logic                   irq_q
);
   if (COUNT_W < 1 || COUNT_W > DATA_W) begin : g_chk
      $error("COUNT_W must be 1 to 32");
   end

   logic [7:0]         evCode_q;
   logic [7:0]         evMask_q;
   logic               evEn_q;
   logic [ST_W-1:0]    status_q;
   logic [ST_W-1:0]    irqEn_q;
   logic [SEG_N-1:0]   stallHit;
   logic [SEG_N-1:0]   renameHit;
   logic [SEG_N-1:0]   pendingQ;
   logic [COUNT_W-1:0] countQ;
   logic               wrapPulse;
   logic               countInc;
   logic               countLd;
   logic [ST_W-1:0]    statusSet;
   logic [ST_W-1:0]    statusClr;

   // A segment mask is legal only as one of the five listed values.
   function automatic logic segMaskOk(input logic [7:0] m);
      return (m == UM_ES) || (m == UM_DS) || (m == UM_FS) ||
             (m == UM_GS) || (m == UM_SEG_ANY); // [R15]
   endfunction

   // Decode one programmed code and mask against this cycle's occurrences.
   function automatic logic eventHit(input logic [7:0] code,
                                     input logic [7:0] m,
                                     input logic [SEG_N-1:0] stl,
                                     input logic [SEG_N-1:0] ren,
                                     input logic robF,
                                     input logic schF);
      logic hit;
      hit = 1'b0;
      case (code)
         EV_SEG_STALL: begin
            hit = segMaskOk(m) && |(stl & m[SEG_N-1:0]); // [R2] [R3] [R4] [R5] [R6] [R16]
         end
         EV_SEG_RENAME: begin
            hit = segMaskOk(m) && |(ren & m[SEG_N-1:0]); // [R7] [R8] [R9] [R10] [R11] [R16]
         end
         EV_RES_STALL: begin
            if (m == UM_RETIRE_F) begin
               hit = robF; // [R12]
            end else if (m == UM_SCHED_F) begin
               hit = schF; // [R13]
            end else begin
               hit = 1'b0; // [R15]
            end
         end
         default: begin
            hit = 1'b0; // [R15]
         end
      endcase
      return hit;
   endfunction

   seg_rename_tracker u_tracker (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .segUpdate (segUpdate),
      .segRetire (segRetire),
      .stallHit  (stallHit),
      .renameHit (renameHit),
      .pendingQ  (pendingQ)
   );

   // One count per cycle at most, even when several segments hit together.
   assign countInc = evEn_q &&
                     eventHit(evCode_q, evMask_q, stallHit, renameHit,
                              retireBufFull, schedFull);
   assign countLd  = regWr && (regAddr == OFS_COUNT);

   event_counter #(
      .WIDTH (COUNT_W)
   ) u_counter (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .inc       (countInc),
      .ldEn      (countLd),
      .ldVal     (regWrData[COUNT_W-1:0]),
      .countQ    (countQ),
      .wrapPulse (wrapPulse)
   );

   // Event selection register.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         evCode_q <= RST_CODE;
         evMask_q <= RST_MASK;
         evEn_q   <= 1'b0;
      end else if (regWr && regAddr == OFS_EVSEL) begin
         evCode_q <= regWrData[EVSEL_CODE_LSB +: 8];
         evMask_q <= regWrData[EVSEL_MASK_LSB +: 8];
         evEn_q   <= regWrData[EVSEL_EN_BIT];
      end
   end

   // Interrupt enable register.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irqEn_q <= RST_IRQ_EN;
      end else if (regWr && regAddr == OFS_IRQ_EN) begin
         irqEn_q <= regWrData[ST_W-1:0];
      end
   end

   // Sticky status; a set in the same cycle as its clear wins.
   always_comb begin
      statusSet               = '0;
      statusSet[ST_WRAP_BIT]  = wrapPulse;
      statusSet[ST_STALL_BIT] = |stallHit;
      statusSet[ST_FULL_BIT]  = retireBufFull | schedFull;
      statusClr = (regWr && regAddr == OFS_IRQ_CLR) ? regWrData[ST_W-1:0] : '0;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= RST_STATUS;
      end else begin
         status_q <= (status_q & ~statusClr) | statusSet;
      end
   end

   // The interrupt is registered one cycle behind the status it reflects.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & irqEn_q);
      end
   end

   // Front-end stall and admission hold toward the pipeline.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         frontStall_q <= 1'b0;
         admitHold_q  <= 1'b0;
      end else begin
         frontStall_q <= |stallHit; // [R1]
         admitHold_q  <= retireBufFull | schedFull; // [R14]
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         regRdData_q <= '0;
      end else if (regRd) begin
         case (regAddr)
            OFS_EVSEL: begin
               regRdData_q <= DATA_W'({evEn_q, 6'h00, evMask_q, evCode_q});
            end
            OFS_COUNT: begin
               regRdData_q <= DATA_W'(countQ);
            end
            OFS_STATUS: begin
               regRdData_q <= DATA_W'(status_q);
            end
            OFS_IRQ_EN: begin
               regRdData_q <= DATA_W'(irqEn_q);
            end
            default: begin
               regRdData_q <= '0;
            end
         endcase
      end else begin
         regRdData_q <= '0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   stall_flag_a: assert property ( // [R1]
      (segUpdate[0] && pendingQ[0] && !segRetire[0]) |=> frontStall_q)
      else $error("stall not raised on repeat ES update");

   es_stall_count_a: assert property ( // [R2]
      (evEn_q && evCode_q == EV_SEG_STALL && evMask_q == UM_ES &&
       stallHit[0] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("ES stall not counted");

   ds_stall_count_a: assert property ( // [R3]
      (evEn_q && evCode_q == EV_SEG_STALL && evMask_q == UM_DS &&
       stallHit[1] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("DS stall not counted");

   fs_stall_count_a: assert property ( // [R4]
      (evEn_q && evCode_q == EV_SEG_STALL && evMask_q == UM_FS &&
       stallHit[2] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("FS stall not counted");

   gs_stall_count_a: assert property ( // [R5]
      (evEn_q && evCode_q == EV_SEG_STALL && evMask_q == UM_GS &&
       stallHit[3] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("GS stall not counted");

   any_stall_count_a: assert property ( // [R6]
      (evEn_q && evCode_q == EV_SEG_STALL && evMask_q == UM_SEG_ANY &&
       (stallHit[2] || stallHit[3]) && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("FS or GS stall not counted under any mask");

   es_rename_count_a: assert property ( // [R7]
      (evEn_q && evCode_q == EV_SEG_RENAME && evMask_q == UM_ES &&
       renameHit[0] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("ES rename not counted");

   ds_rename_count_a: assert property ( // [R8]
      (evEn_q && evCode_q == EV_SEG_RENAME && evMask_q == UM_DS &&
       renameHit[1] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("DS rename not counted");

   fs_rename_count_a: assert property ( // [R9]
      (evEn_q && evCode_q == EV_SEG_RENAME && evMask_q == UM_FS &&
       renameHit[2] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("FS rename not counted");

   gs_rename_count_a: assert property ( // [R10]
      (evEn_q && evCode_q == EV_SEG_RENAME && evMask_q == UM_GS &&
       renameHit[3] && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("GS rename not counted");

   any_rename_count_a: assert property ( // [R11]
      (evEn_q && evCode_q == EV_SEG_RENAME && evMask_q == UM_SEG_ANY &&
       (|renameHit) && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("rename not counted under any mask");

   es_only_mask_a: assert property ( // [R16]
      (evEn_q && evCode_q == EV_SEG_RENAME && evMask_q == UM_ES &&
       !renameHit[0] && !countLd)
      |=> $stable(countQ))
      else $error("ES mask counted another segment");

   rob_full_count_a: assert property ( // [R12]
      (evEn_q && evCode_q == EV_RES_STALL && evMask_q == UM_RETIRE_F &&
       !countLd)
      |=> countQ == $past(countQ) + COUNT_W'($past(retireBufFull)))
      else $error("retire buffer full cycle count wrong");

   sched_full_count_a: assert property ( // [R13]
      (evEn_q && evCode_q == EV_RES_STALL && evMask_q == UM_SCHED_F &&
       schedFull && !countLd)
      |=> countQ == $past(countQ) + COUNT_W'(1))
      else $error("scheduler full cycle not counted");

   admit_hold_a: assert property ( // [R14]
      (retireBufFull || schedFull) |=> admitHold_q)
      else $error("admission not held while full");

   bad_mask_a: assert property ( // [R15]
      (evEn_q && evCode_q == EV_SEG_STALL && !segMaskOk(evMask_q) && !countLd)
      |=> $stable(countQ))
      else $error("unlisted mask changed the count");

   count_off_a: assert property ( // [R15]
      (!evEn_q && !countLd) |=> $stable(countQ))
      else $error("disabled counter changed");
endmodule // seg_stall_event_unit
`default_nettype wire

//--- verif/pipe_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the rename, retire and scheduling stages, paced by the bench's random word.
module pipe_partner
   import seg_event_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             go,
   input  wire logic [31:0]      rnd,
   output logic      [SEG_N-1:0] segUpdate,
   output logic      [SEG_N-1:0] segRetire,
   output logic                  retireBufFull,
   output logic                  schedFull
);
   logic [SEG_N-1:0] pendQ;
   logic [SEG_N-1:0] pendD;

   // A refused update leaves the segment owed a retire, so the stall lasts until retire.
   assign pendD = (pendQ & ~segRetire) | segUpdate;

   // Retires come only for owed segments and at a random pace, so stalls may last long.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pendQ         <= '0;
         segUpdate     <= '0;
         segRetire     <= '0;
         retireBufFull <= 1'b0;
         schedFull     <= 1'b0;
      end else begin
         pendQ         <= pendD;
         segUpdate     <= go ? rnd[3:0] : '0;
         segRetire     <= go ? (pendD & rnd[11:8]) : '0;
         retireBufFull <= go & rnd[4] & rnd[5];
         schedFull     <= go & rnd[6] & rnd[7];
      end
   end
endmodule // pipe_partner
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      nCompared++; \
      if ((got) !== (ex)) begin \
         failCount++; \
         $display("ERROR %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb
   import seg_event_pkg::*;
;
   localparam int CW = 8;
   logic              clk_sys = 1'b0;
   logic              arst_n = 1'b0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic              regWr = 1'b0;
   logic              regRd = 1'b0;
   logic [DATA_W-1:0] regRdData_q;
   logic [SEG_N-1:0]  segUpdate, segRetire, pendM = '0, stl, ren;
   logic              retireBufFull, schedFull, frontStall_q, admitHold_q, irq_q;
   logic              go = 1'b0, rdSeen = 1'b0, expStall = 1'b0, expHold = 1'b0, hit, countWr;
   logic [DATA_W-1:0] expRd;
   logic [31:0]       rnd = 32'h096614e5;
   logic [DATA_W-1:0] expQ[$];
   logic [15:0]       selM = '0;
   logic              selEn = 1'b0;
   logic [CW-1:0]     expCnt = '0;
   logic [ST_W-1:0]   expSt = '0;
   int                failCount = 0, nCompared = 0, cycles = 0;
   logic [15:0] tbl[16] = '{16'h01d4, 16'h02d4, 16'h04d4, 16'h08d4, 16'h0fd4, 16'h03d4,
      16'h01d5, 16'h02d5, 16'h04d5, 16'h08d5, 16'h0fd5, 16'h00d5,
      16'h01dc, 16'h02dc, 16'h04dc, 16'h01d2};

   always #5 clk_sys = ~clk_sys;

   seg_stall_event_unit #(.COUNT_W(CW)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData_q(regRdData_q), .segUpdate(segUpdate), .segRetire(segRetire),
      .retireBufFull(retireBufFull), .schedFull(schedFull), .frontStall_q(frontStall_q),
      .admitHold_q(admitHold_q), .irq_q(irq_q));

   pipe_partner u_partner (.clk_sys(clk_sys), .arst_n(arst_n), .go(go), .rnd(rnd),
      .segUpdate(segUpdate), .segRetire(segRetire), .retireBufFull(retireBufFull),
      .schedFull(schedFull));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction

   // Only listed code and mask pairs count; a segment mask picks segments bit by bit.
   function automatic logic qual(input logic [15:0] s, input logic [3:0] st, input logic [3:0] rn,
                                 input logic rf, input logic sf);
      logic segOk;
      segOk = s[15:8] inside {UM_ES, UM_DS, UM_FS, UM_GS, UM_SEG_ANY};
      case (s[7:0])
         EV_SEG_STALL:  return segOk && |(st & s[11:8]);
         EV_SEG_RENAME: return segOk && |(rn & s[11:8]);
         EV_RES_STALL:  return (s[15:8] == UM_RETIRE_F && rf) || (s[15:8] == UM_SCHED_F && sf);
         default:       return 1'b0;
      endcase
   endfunction

   task automatic endOfTest();
      $display("Comparisons %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask

   // The expected word is noted now and compared when the read data appear.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      expQ.push_back(e);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
   endtask

   // A nonzero word is replayed every cycle; zero asks for fresh random words.
   task automatic run(input int n, input logic [31:0] v);
      repeat (n) begin
         @(posedge clk_sys);
         go <= 1'b1;
         rnd <= (v != 0) ? v : lfsr(rnd);
      end
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // Cycle ceiling; a hang counts as a mismatch and still reaches the one verdict.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 4000) begin
         failCount++;
         endOfTest();
      end
   end

   // Reference model: expectations come from the pins the partner drives and the bus writes.
   always @(posedge clk_sys) begin
      `CHK("frontStall", expStall, frontStall_q)
      `CHK("admitHold", expHold, admitHold_q)
      // The note is popped once, so a mismatch prints the word that was compared.
      if (rdSeen) begin
         expRd = expQ.pop_front();
         `CHK("readData", expRd, regRdData_q)
      end
      rdSeen <= regRd;
      countWr = regWr && regAddr == OFS_COUNT;
      stl = segUpdate & pendM & ~segRetire;
      ren = segUpdate & (~pendM | segRetire);
      hit = selEn && qual(selM, stl, ren, retireBufFull, schedFull);
      expStall <= |stl;
      expHold <= retireBufFull | schedFull;
      pendM <= (pendM & ~segRetire) | segUpdate;
      expSt <= (expSt & ~((regWr && regAddr == OFS_IRQ_CLR) ? regWrData[2:0] : 3'h0))
               | {retireBufFull | schedFull, |stl, hit && !countWr && (&expCnt)};
      if (hit)
         expCnt <= expCnt + 1'b1;
      if (countWr)
         expCnt <= regWrData[CW-1:0];
      if (regWr && regAddr == OFS_EVSEL) begin
         selM <= regWrData[15:0];
         selEn <= regWrData[EVSEL_EN_BIT];
      end
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(OFS_EVSEL, 32'h0);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_IRQ_EN, 32'h0);
      rd(OFS_COUNT, 32'h0);
      rd(8'h14, 32'h0);
      // Every listed pair, plus unlisted masks and an unlisted code, under random traffic.
      foreach (tbl[i]) begin
         wr(OFS_COUNT, 32'h0);
         wr(OFS_EVSEL, {9'h0, 1'b1, 6'h0, tbl[i]});
         run(40, 32'h0);
         wr(OFS_EVSEL, {16'h0, tbl[i]});
         rd(OFS_COUNT, {24'h0, expCnt});
         rd(OFS_COUNT, {24'h0, expCnt});
         rd(OFS_EVSEL, {16'h0, tbl[i]});
      end
      rd(OFS_STATUS, {29'h0, expSt});
      rd(OFS_IRQ_CLR, 32'h0);
      // Interrupt raised, masked, then cleared at the source.
      wr(OFS_IRQ_EN, 32'h2);
      repeat (3) @(posedge clk_sys);
      `CHK("irqRaised", expSt[ST_STALL_BIT], irq_q)
      wr(OFS_IRQ_EN, 32'h0);
      repeat (3) @(posedge clk_sys);
      `CHK("irqMasked", 1'b0, irq_q)
      wr(OFS_IRQ_EN, 32'h7);
      wr(OFS_IRQ_CLR, 32'h7);
      repeat (3) @(posedge clk_sys);
      `CHK("irqCleared", 1'b0, irq_q)
      rd(OFS_STATUS, 32'h0);
      // Counter wrap: preset to all ones, then two full cycles of the retire buffer.
      wr(OFS_COUNT, 32'hff);
      wr(OFS_EVSEL, {9'h0, 1'b1, 6'h0, UM_RETIRE_F, EV_RES_STALL});
      run(2, 32'h30);
      `CHK("irqWrap", 1'b1, irq_q)
      rd(OFS_COUNT, {24'h0, expCnt});
      rd(OFS_STATUS, {29'h0, expSt});
      wr(8'h20, 32'hffffffff);
      rd(OFS_COUNT, {24'h0, expCnt});
      repeat (3) @(posedge clk_sys);
      endOfTest();
   end
endmodule // tb
`default_nettype wire
